// *** dutc_ext_src.sv ***
`timescale 1ns/10ps
`default_nettype none
module dutc_ext_src (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic go,
  input wire logic [7:0] pulses,
  input wire logic [2:0] half,
  output logic busy,
  output logic pin
);
  logic [7:0] left_r;
  logic [2:0] cnt_r;
  assign busy = left_r != 8'h00;
  ////////////////////////////////////////////////////////////////////////////
  // pin parks low between bursts, never free-running
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      left_r <= 8'h00;
      cnt_r <= 3'h0;
      pin <= 1'b0;
    end else if (go) begin
      left_r <= pulses;
      cnt_r <= 3'h0;
    end else if (busy && cnt_r == half) begin
      cnt_r <= 3'h0;
      pin <= ~pin;
      if (pin) begin
        left_r <= left_r - 8'h01;
      end
    end else if (busy) begin
      cnt_r <= cnt_r + 3'h1;
    end
  end
endmodule
`default_nettype wire

// *** dutc_pkg.sv ***
`default_nettype none
package dutc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register word indices; byte address is four times the index
  localparam logic [4:0] IDX_PRESCALE = 5'h01;
  localparam logic [4:0] IDX_IRQ_MASK = 5'h05;
  localparam logic [4:0] IDX_IRQ_FLAG = 5'h06;
  localparam logic [4:0] IDX_CTRL = 5'h07;
  localparam logic [4:0] IDX_T1_LOW = 5'h08;
  localparam logic [4:0] IDX_T1_HIGH = 5'h09;
  localparam logic [4:0] IDX_T0 = 5'h0A;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and field layout
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'hBF;
  localparam logic [1:0] MASK_RST = 2'h3;
  localparam logic [1:0] PRESCALE_RST = 2'h0;
  localparam logic [7:0] T1_BUF_RST = 8'h00;
  localparam int unsigned PS_LSB = 4;
  localparam int unsigned FLG_T0 = 0;
  localparam int unsigned FLG_T1 = 1;

  ////////////////////////////////////////////////////////////////////////////
  // timer widths and prescaler shape
  localparam int unsigned T0_W = 8;
  localparam int unsigned T1_W = 16;
  localparam int unsigned PS_W = 5;
  localparam logic [4:0] PS_MASK_DIV4 = 5'h03;
  localparam logic [4:0] PS_MASK_DIV8 = 5'h07;
  localparam logic [4:0] PS_MASK_DIV16 = 5'h0F;
  localparam logic [4:0] PS_MASK_DIV32 = 5'h1F;

  typedef struct packed {
    logic ext_mode;
    logic unused6;
    logic t1_clk;
    logic t0_clk;
    logic t1_edge;
    logic t0_edge;
    logic t1_en;
    logic t0_en;
  } dutc_ctl_t;

endpackage
`default_nettype wire

// *** dutc_timer.sv ***
`timescale 1ns/10ps
`default_nettype none
module dutc_timer #(
  parameter int unsigned W = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic tick,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic [W-1:0] count,
  output logic [W-1:0] preload,
  output logic overflow
);

  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;
  logic [W-1:0] preload_r;
  wire step = enable & tick;

  // a software load in the same cycle beats the count
  assign overflow = step & ~load & (&count_r);
  assign count_nxt = load ? load_val :
                     overflow ? preload_r :
                     step ? count_r + {{(W-1){1'b0}}, 1'b1} : count_r;
  assign count = count_r;
  assign preload = preload_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= '0;
      preload_r <= '0;
    end else begin
      count_r <= count_nxt;
      if (load) begin
        preload_r <= load_val;
      end
    end
  end

endmodule
`default_nettype wire

// *** dutc_top.sv ***
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module dutc_top
  import dutc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic slow_crystal_clock,
  input wire logic timer_one_ext_clock,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  dutc_ctl_t ctl_r;
  logic [1:0] ps_r;
  logic [1:0] mask_r;
  logic [1:0] flag_r;
  logic [1:0] flag_nxt;
  logic [7:0] t1_buf_r;
  logic [PS_W-1:0] ps_cnt_r;
  logic [31:0] readdata_r;
  logic waitrequest_r;
  logic irq_r;
  logic [1:0] pin_s1_r;
  logic [1:0] pin_s2_r;
  logic [1:0] pin_s3_r;
  logic [T0_W-1:0] t0_cnt;
  logic [T0_W-1:0] t0_pre;
  logic [T1_W-1:0] t1_cnt;
  logic [T1_W-1:0] t1_pre;
  logic t0_ovf;
  logic t1_ovf;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode: one access per request, answered one cycle later

  wire acc = (read | write) & waitrequest_r;
  wire wr_acc = acc & write & byteenable[0];
  wire rd_acc = acc & read;
  wire [7:0] wdata8 = writedata[7:0];
  wire hit_ps = address == IDX_PRESCALE;
  wire hit_mask = address == IDX_IRQ_MASK;
  wire hit_flag = address == IDX_IRQ_FLAG;
  wire hit_ctrl = address == IDX_CTRL;
  wire hit_t1l = address == IDX_T1_LOW;
  wire hit_t1h = address == IDX_T1_HIGH;
  wire hit_t0 = address == IDX_T0;
  wire t0_load = wr_acc & hit_t0;
  wire t1_low_wr = wr_acc & hit_t1l;
  wire t1_high_wr = wr_acc & hit_t1h;
  wire t1_high_rd = rd_acc & hit_t1h;
  wire t1_low_rd = rd_acc & hit_t1l;
  wire [7:0] t1_lo = t1_cnt[7:0];
  wire [7:0] t1_hi = t1_cnt[T1_W-1:8];
  wire [7:0] rd_ps = 8'({6'h00, ps_r} << PS_LSB);

  // unmapped words read as zero and swallow writes
  wire [7:0] rd_byte = hit_ps ? rd_ps :
                       hit_mask ? {6'h00, mask_r} :
                       hit_flag ? {6'h00, flag_r} :
                       hit_ctrl ? ctl_r :
                       hit_t1l ? t1_buf_r :
                       hit_t1h ? t1_hi :
                       hit_t0 ? t0_cnt : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: bit 0 crystal, bit 1 external clock

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_r <= 2'h0;
      pin_s2_r <= 2'h0;
      pin_s3_r <= 2'h0;
    end else begin
      pin_s1_r <= {timer_one_ext_clock, slow_crystal_clock};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  wire [1:0] pin_rise = pin_s2_r & ~pin_s3_r;
  wire [1:0] pin_fall = ~pin_s2_r & pin_s3_r;

  ////////////////////////////////////////////////////////////////////////////
  // clock selection and timer zero prescaler
  // the system clock has no edge to pick, so its source is high every cycle; timer zero still ticks only at prescaler end

  wire t0_xtal = ctl_r.t0_edge ? pin_fall[0] : pin_rise[0];
  wire t1_xtal = ctl_r.t1_edge ? pin_fall[0] : pin_rise[0];
  wire t1_ext = ctl_r.t1_edge ? pin_fall[1] : pin_rise[1];
  wire t0_src = ctl_r.t0_clk ? 1'b1 : t0_xtal;
  wire t1_int = ctl_r.t1_clk ? 1'b1 : t1_xtal;
  wire t1_tick = ctl_r.ext_mode ? t1_ext : t1_int;
  wire [PS_W-1:0] ps_mask = (ps_r == 2'h0) ? PS_MASK_DIV4 :
                            (ps_r == 2'h1) ? PS_MASK_DIV8 :
                            (ps_r == 2'h2) ? PS_MASK_DIV16 : PS_MASK_DIV32;
  wire ps_end = &(ps_cnt_r | ~ps_mask);
  wire t0_tick = t0_src & ps_end;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ps_cnt_r <= '0;
    end else if (ctl_r.t0_en & t0_src) begin
      ps_cnt_r <= ps_end ? '0 : ps_cnt_r + {{(PS_W-1){1'b0}}, 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // the two counters

  dutc_timer #(.W(T0_W)) u_t0 (
    .clk(clk),
    .reset_n(reset_n),
    .enable(ctl_r.t0_en),
    .tick(t0_tick),
    .load(t0_load),
    .load_val(wdata8),
    .count(t0_cnt),
    .preload(t0_pre),
    .overflow(t0_ovf)
  );

  dutc_timer #(.W(T1_W)) u_t1 (
    .clk(clk),
    .reset_n(reset_n),
    .enable(ctl_r.t1_en),
    .tick(t1_tick),
    .load(t1_high_wr),
    .load_val({wdata8, t1_buf_r}),
    .count(t1_cnt),
    .preload(t1_pre),
    .overflow(t1_ovf)
  );

  ////////////////////////////////////////////////////////////////////////////
  // software registers

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_r <= CTRL_RST;
      ps_r <= PRESCALE_RST;
      mask_r <= MASK_RST;
    end else begin
      if (wr_acc & hit_ctrl) begin
        ctl_r <= wdata8 & CTRL_WMASK;
      end
      if (wr_acc & hit_ps) begin
        ps_r <= wdata8[PS_LSB+1:PS_LSB];
      end
      if (wr_acc & hit_mask) begin
        mask_r <= wdata8[1:0];
      end
    end
  end

  // holding byte for the 16-bit timer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      t1_buf_r <= T1_BUF_RST;
    end else if (t1_low_wr) begin
      t1_buf_r <= wdata8;
    end else if (t1_high_rd) begin
      t1_buf_r <= t1_lo;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // overflow flags, cleared by a read; a new overflow beats the clear

  assign flag_nxt = (flag_r & ~{2{rd_acc & hit_flag}}) | {t1_ovf, t0_ovf};
  wire irq_pend = |(flag_r & ~mask_r);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_r <= 2'h0;
      irq_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      irq_r <= irq_pend;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus answer

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      waitrequest_r <= 1'b1;
      readdata_r <= 32'h0000_0000;
    end else begin
      waitrequest_r <= ~acc;
      if (rd_acc) begin
        readdata_r <= {24'h00_0000, rd_byte};
      end
    end
  end

  assign readdata = readdata_r;
  assign waitrequest = waitrequest_r;
  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_t0_hold;
    @(posedge clk) disable iff (!reset_n)
    !ctl_r.t0_en && !t0_load |=> $stable(t0_cnt);
  endproperty
  a_t0_hold: assert property (p_t0_hold) else $error("timer zero moved while off");

  property p_t1_hold;
    @(posedge clk) disable iff (!reset_n)
    !ctl_r.t1_en && !t1_high_wr ##1 !ctl_r.t1_en && !t1_high_wr |=> $stable(t1_cnt);
  endproperty
  a_t1_hold: assert property (p_t1_hold) else $error("timer one moved while off");

  property p_t0_step;
    @(posedge clk) disable iff (!reset_n)
    t0_tick && ctl_r.t0_en && !t0_load && t0_cnt != 8'hFF |=> t0_cnt == $past(t0_cnt) + 8'h01;
  endproperty
  a_t0_step: assert property (p_t0_step) else $error("timer zero missed a step");

  property p_t0_reload;
    @(posedge clk) disable iff (!reset_n)
    t0_ovf |=> t0_cnt == $past(t0_pre);
  endproperty
  a_t0_reload: assert property (p_t0_reload) else $error("timer zero not reloaded");

  property p_flag_set;
    @(posedge clk) disable iff (!reset_n)
    t0_ovf || t1_ovf |=> (flag_r & $past({t1_ovf, t0_ovf})) == $past({t1_ovf, t0_ovf});
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("overflow flag not set");

  property p_irq_raise;
    @(posedge clk) disable iff (!reset_n)
    t0_ovf && !mask_r[0] ##1 !mask_r[0] |=> irq_r;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("unmasked overflow gave no irq");

  property p_low_write;
    @(posedge clk) disable iff (!reset_n)
    t1_low_wr |=> $stable(t1_pre);
  endproperty
  a_low_write: assert property (p_low_write) else $error("low write changed preload");

  property p_high_write;
    @(posedge clk) disable iff (!reset_n)
    t1_high_wr |=> t1_pre == {$past(wdata8), $past(t1_buf_r)};
  endproperty
  a_high_write: assert property (p_high_write) else $error("preload not loaded as a pair");

  property p_high_read;
    @(posedge clk) disable iff (!reset_n)
    t1_high_rd |=> t1_buf_r == $past(t1_lo);
  endproperty
  a_high_read: assert property (p_high_read) else $error("low byte not latched");

  property p_low_read;
    @(posedge clk) disable iff (!reset_n)
    t1_low_rd |=> readdata_r[7:0] == $past(t1_buf_r) && !waitrequest_r;
  endproperty
  a_low_read: assert property (p_low_read) else $error("low read not from buffer");

  property p_t1_step;
    @(posedge clk) disable iff (!reset_n)
    t1_tick && ctl_r.t1_en && !t1_high_wr && t1_cnt != 16'hFFFF |=> t1_cnt == $past(t1_cnt) + 16'h0001;
  endproperty
  a_t1_step: assert property (p_t1_step) else $error("timer one missed a step");

  property p_t1_reload;
    @(posedge clk) disable iff (!reset_n)
    t1_ovf |=> t1_cnt == $past(t1_pre);
  endproperty
  a_t1_reload: assert property (p_t1_reload) else $error("timer one not reloaded");

  property p_t0_wrap;
    @(posedge clk) disable iff (!reset_n)
    t0_tick && ctl_r.t0_en && !t0_load && t0_cnt == 8'hFF |-> t0_ovf;
  endproperty
  a_t0_wrap: assert property (p_t0_wrap) else $error("timer zero rollover gave no request");

  property p_t1_wrap;
    @(posedge clk) disable iff (!reset_n)
    t1_tick && ctl_r.t1_en && !t1_high_wr && t1_cnt == 16'hFFFF |-> t1_ovf;
  endproperty
  a_t1_wrap: assert property (p_t1_wrap) else $error("timer one rollover gave no request");

  // system clock picked for timer one means one step every cycle
  property p_t1_sysclk;
    @(posedge clk) disable iff (!reset_n)
    ctl_r.t1_en && ctl_r.t1_clk && !ctl_r.ext_mode && !t1_high_wr && t1_cnt != 16'hFFFF
      |=> t1_cnt == $past(t1_cnt) + 16'h0001;
  endproperty
  a_t1_sysclk: assert property (p_t1_sysclk) else $error("timer one idle on system clock");

  property p_irq_masked;
    @(posedge clk) disable iff (!reset_n)
    (flag_r & ~mask_r) == 2'h0 |=> !irq_r;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("masked flag raised irq");

  property p_flag_keep;
    @(posedge clk) disable iff (!reset_n)
    !(rd_acc && hit_flag) |=> (flag_r & $past(flag_r)) == $past(flag_r);
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("flag lost without a read");

  property p_flag_clear;
    @(posedge clk) disable iff (!reset_n)
    rd_acc && hit_flag |=> flag_r == $past({t1_ovf, t0_ovf});
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag read did not clear");

  c_t0_ovf: cover property (@(posedge clk) disable iff (!reset_n) t0_ovf);
  c_t1_ovf: cover property (@(posedge clk) disable iff (!reset_n) t1_ovf);
  c_irq: cover property (@(posedge clk) disable iff (!reset_n) $rose(irq_r));
  c_t1_sys: cover property (@(posedge clk) disable iff (!reset_n) t1_ovf && ctl_r.t1_clk && !ctl_r.ext_mode);
  c_pair_read: cover property (@(posedge clk) disable iff (!reset_n) t1_high_rd ##[1:20] t1_low_rd);

endmodule
`default_nettype wire

// *** dutc_top_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module dutc_top_tb;
  import dutc_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic go = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest, irq, xtal, extc, xbusy, ebusy;
  logic [7:0] n_x = 8'h00, n_e = 8'h00, q;
  logic [2:0] half = 3'h1;
  logic [31:0] seed = 32'hD06CA0FF;
  int num_errors = 0;
  int tests_run = 0;
  always #2.5 clk = ~clk;
  dutc_top DUT (.clk(clk), .reset_n(reset_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
    .slow_crystal_clock(xtal), .timer_one_ext_clock(extc), .irq(irq));
  dutc_ext_src u_x (.clk(clk), .reset_n(reset_n), .go(go), .pulses(n_x), .half(half),
    .busy(xbusy), .pin(xtal));
  dutc_ext_src u_e (.clk(clk), .reset_n(reset_n), .go(go), .pulses(n_e), .half(half),
    .busy(ebusy), .pin(extc));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // expected count after n ticks, reloading from the start value past top
  function automatic logic [15:0] after_ticks(input logic [15:0] start, input logic [15:0] top, input int n);
    logic [15:0] v;
    v = start;
    for (int k = 0; k < n; k++) begin
      v = (v == top) ? start : v + 16'h0001;
    end
    return v;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // idle edge after release so back-to-back calls never drive twice in a step
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    address <= a;
    writedata <= {24'h0, d};
    write <= wr;
    read <= ~wr;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    q = readdata[7:0];
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk({8'h0, q}, {8'h0, e});
  endtask
  // both sources run together, so a wrong source select shows up
  task automatic burst(input logic [7:0] ne, input logic [7:0] nx);
    n_e <= ne;
    n_x <= nx;
    half <= 3'(rnd() % 6 + 1);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (xbusy || ebusy) @(posedge clk);
    repeat (6) @(posedge clk);
  endtask
  task automatic wait_irq();
    for (int n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge clk);
    chk(irq, 1'b1);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
  initial begin
    logic [15:0] s, e;
    logic [7:0] m, a, b;
    time t0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk(irq, 1'b0);
    rd(IDX_CTRL, 8'h00);
    rd(IDX_IRQ_MASK, 8'h03);
    rd(IDX_IRQ_FLAG, 8'h00);
    rd(IDX_PRESCALE, 8'h00);
    wr(5'h1F, 8'hFF);
    rd(5'h1F, 8'h00);
    wr(IDX_CTRL, 8'hFF);
    rd(IDX_CTRL, 8'hBF);
    wr(IDX_CTRL, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      m = 8'h02 | (i[0] ? 8'h08 : 8'h00) | (i[1] ? 8'h00 : 8'h80);
      s = 16'(rnd() % 32'hEF00);
      a = 8'(rnd() % 40 + 1);
      b = 8'(rnd() % 40 + 1);
      wr(IDX_T1_LOW, s[7:0]);
      wr(IDX_T1_HIGH, s[15:8]);
      wr(IDX_CTRL, m);
      burst(a, b);
      wr(IDX_CTRL, m & 8'hFD);
      burst(a, b);
      e = after_ticks(s, 16'hFFFF, m[7] ? a : b);
      wr(IDX_T1_LOW, 8'h5A);
      rd(IDX_T1_LOW, 8'h5A);
      rd(IDX_T1_HIGH, e[15:8]);
      rd(IDX_T1_LOW, e[7:0]);
    end
    $display("test timer one sources done");
    wr(IDX_T1_LOW, 8'hFE);
    wr(IDX_T1_HIGH, 8'hFF);
    wr(IDX_CTRL, 8'h82);
    burst(8'd3, 8'd0);
    chk(irq, 1'b0);
    rd(IDX_IRQ_FLAG, 8'h02);
    rd(IDX_IRQ_FLAG, 8'h00);
    wr(IDX_IRQ_MASK, 8'h01);
    burst(8'd2, 8'd0);
    chk(irq, 1'b1);
    wr(IDX_CTRL, 8'h00);
    rd(IDX_T1_HIGH, 8'hFF);
    rd(IDX_T1_LOW, 8'hFF);
    rd(IDX_IRQ_FLAG, 8'h02);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    $display("test timer one overflow done");
    wr(IDX_T1_LOW, 8'hC0);
    wr(IDX_T1_HIGH, 8'hFF);
    wr(IDX_CTRL, 8'h22);
    wait_irq();
    t0 = $time;
    rd(IDX_IRQ_FLAG, 8'h02);
    wait_irq();
    chk(16'(($time - t0) / 5), 16'h0040);
    wr(IDX_CTRL, 8'h00);
    rd(IDX_IRQ_FLAG, 8'h02);
    $display("test timer one system clock done");
    for (int r = 0; r < 4; r++) begin
      wr(IDX_T0, 8'hF0);
      wr(IDX_PRESCALE, 8'(r << 4));
      wr(IDX_IRQ_MASK, 8'h02);
      wr(IDX_CTRL, 8'h11);
      wait_irq();
      t0 = $time;
      rd(IDX_IRQ_FLAG, 8'h01);
      wait_irq();
      chk(16'(($time - t0) / 5), 16'(64 << r));
      wr(IDX_CTRL, 8'h00);
      rd(IDX_IRQ_FLAG, 8'h01);
    end
    $display("test timer zero prescale done");
    for (int i = 0; i < 2; i++) begin
      s = 16'(rnd() % 32'hE0);
      wr(IDX_PRESCALE, 8'h00);
      wr(IDX_T0, s[7:0]);
      wr(IDX_CTRL, i ? 8'h05 : 8'h01);
      burst(8'd20, 8'd32);
      wr(IDX_CTRL, 8'h00);
      rd(IDX_T0, 8'(after_ticks(s, 16'h00FF, 8)));
    end
    $display("test timer zero crystal done");
    print_verdict();
  end
endmodule
`default_nettype wire
